// >>> design/sssrq_cpu_stream.sv
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sssrq_cpu_stream (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output      logic [31:0]              prdata,
  output      logic                     pready,
  output      logic                     pslverr,
  input  wire logic                     set_valid,
  input  wire sssrq_pkg::sssrq_set_cmd_t set_cmd,
  output      logic                     set_ready,
  input  wire logic                     quiesce_req,
  output      logic                     up_valid,
  output      sssrq_pkg::sssrq_beat_t    up_beat,
  input  wire logic                     up_ready
);

  sssrq_pkg::sssrq_state_t     st_reg;
  sssrq_pkg::sssrq_state_t     st_next;
  sssrq_pkg::sssrq_rel_entry_t q_push_data;
  sssrq_pkg::sssrq_rel_entry_t q_head;
  logic                        q_push;
  logic                        q_pop;
  logic                        q_full;
  logic                        q_empty;
  logic [1:0]                  q_count;
  logic                        setup_ph;
  logic                        access_ph;
  logic                        ack_window;
  logic                        set_fire;
  logic                        new_on;
  logic                        held_on;
  logic                        hit_g0;
  logic                        hit_g1;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // enable of the group a set belongs to: qualifier picks secure group 1
  function automatic logic grp_on(input logic grp, input logic mod, input logic [2:0] en);
    if (!grp)
      grp_on = en[sssrq_pkg::SSSRQ_EN_G0];
    else if (mod)
      grp_on = en[sssrq_pkg::SSSRQ_EN_G1S];
    else
      grp_on = en[sssrq_pkg::SSSRQ_EN_G1NS];
  endfunction

  function automatic sssrq_pkg::sssrq_rel_entry_t to_rel(input sssrq_pkg::sssrq_set_cmd_t c);
    to_rel.virt              = c.virt;
    to_rel.number_width_code = c.number_width_code;
    to_rel.interrupt_number  = c.interrupt_number;
  endfunction

  // ----------------------------------------------------------------
  // release queue
  // ----------------------------------------------------------------
  sssrq_rel_queue i_sssrq_rel_queue (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .push      (q_push),
    .push_data (q_push_data),
    .pop       (q_pop),
    .head      (q_head),
    .full      (q_full),
    .empty     (q_empty),
    .count     (q_count)
  );

  // bus phases and hand-shakes
  assign setup_ph   = psel & ~penable;
  assign access_ph  = psel & penable;
  // sets are held off across an acknowledge read so the value read is the one consumed
  assign ack_window = psel & ~pwrite & ((paddr == sssrq_pkg::SSSRQ_OFF_ACK_G0) |
                                        (paddr == sssrq_pkg::SSSRQ_OFF_ACK_G1));
  assign set_ready  = ~q_full & ~ack_window;
  assign set_fire   = set_valid & set_ready;
  assign new_on     = grp_on(set_cmd.grp, set_cmd.mod, st_reg.en);
  assign held_on    = grp_on(st_reg.held.grp, st_reg.held.mod, st_reg.en);
  assign hit_g0     = st_reg.held_valid & held_on & ~st_reg.held.grp;
  assign hit_g1     = st_reg.held_valid & held_on & st_reg.held.grp;
  assign pready     = access_ph;
  assign prdata     = st_reg.prdata;
  assign pslverr    = st_reg.pslverr;
  assign up_valid   = (st_reg.seq != sssrq_pkg::SSSRQ_SEQ_IDLE);
  assign up_beat    = st_reg.beat;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic pick;
    pick        = 1'b0;
    st_next     = st_reg;
    q_push      = 1'b0;
    q_push_data = '0;
    q_pop       = 1'b0;

    // arriving set
    if (set_fire)
    begin
      if (!new_on)
      begin
        q_push      = 1'b1;
        q_push_data = to_rel(set_cmd);
      end
      else
      begin
        q_push          = st_reg.held_valid;
        q_push_data     = to_rel(st_reg.held);
        st_next.held    = set_cmd;
        st_next.held_valid = 1'b1;
      end
    end
    else if (st_reg.held_valid && (!held_on || st_reg.quiesce_pend) && !q_full && !ack_window)
    begin
      q_push             = 1'b1;
      q_push_data        = to_rel(st_reg.held);
      st_next.held_valid = 1'b0;
    end

    // upstream beat sequencer: a beat advances when taken
    if (st_reg.seq == sssrq_pkg::SSSRQ_SEQ_IDLE || up_ready)
    begin
      case (st_reg.seq)
        sssrq_pkg::SSSRQ_SEQ_UC_HDR:
        begin
          st_next.seq       = sssrq_pkg::SSSRQ_SEQ_UC_DATA;
          st_next.beat.data = {8'h00, 5'h00, st_reg.en};
          st_next.beat.last = 1'b1;
        end
        sssrq_pkg::SSSRQ_SEQ_REL_HDR:
        begin
          st_next.seq       = sssrq_pkg::SSSRQ_SEQ_REL_LO;
          st_next.beat.data = st_reg.rel.interrupt_number[15:0];
          st_next.beat.last = (st_reg.rel.number_width_code == sssrq_pkg::SSSRQ_WCODE_16);
        end
        sssrq_pkg::SSSRQ_SEQ_REL_LO:
        begin
          if (st_reg.rel.number_width_code != sssrq_pkg::SSSRQ_WCODE_16)
          begin
            st_next.seq       = sssrq_pkg::SSSRQ_SEQ_REL_HI;
            st_next.beat.data = {8'h00, st_reg.rel.interrupt_number[23:16]};
            st_next.beat.last = 1'b1;
          end
          else
          begin
            pick = 1'b1;
          end
        end
        default:
        begin
          pick = 1'b1;
        end
      endcase

      if (pick)
      begin
        st_next.seq  = sssrq_pkg::SSSRQ_SEQ_IDLE;
        st_next.beat = '0;
        if (st_reg.uc_pend)
        begin
          st_next.seq       = sssrq_pkg::SSSRQ_SEQ_UC_HDR;
          st_next.beat.data = {sssrq_pkg::SSSRQ_UC_ID_PHYS, sssrq_pkg::SSSRQ_UC_LEN_PHYS,
                               sssrq_pkg::SSSRQ_CMD_UPCTRL};
          st_next.uc_pend   = 1'b0;
        end
        else if (!q_empty)
        begin
          q_pop             = 1'b1;
          st_next.rel       = q_head;
          st_next.seq       = sssrq_pkg::SSSRQ_SEQ_REL_HDR;
          st_next.beat.data = {8'h00, q_head.number_width_code, 1'b0, q_head.virt,
                               sssrq_pkg::SSSRQ_CMD_RELEASE};
        end
        // a set landing this cycle would be held behind the ack, so it waits
        else if (st_reg.quiesce_pend && !st_reg.held_valid && !q_push && !set_fire)
        begin
          st_next.seq          = sssrq_pkg::SSSRQ_SEQ_QACK;
          st_next.beat.data    = {12'h000, sssrq_pkg::SSSRQ_CMD_QACK};
          st_next.beat.last    = 1'b1;
          st_next.quiesce_pend = 1'b0;
        end
      end
    end

    // a new quiesce request wins over the clear above
    if (quiesce_req)
      st_next.quiesce_pend = 1'b1;

    // bus setup: read data and error captured ahead of the access phase
    if (setup_ph)
    begin
      st_next.pslverr = 1'b0;
      st_next.prdata  = '0;
      case (paddr)
        sssrq_pkg::SSSRQ_OFF_ENABLE: st_next.prdata = {29'h0, st_reg.en};
        sssrq_pkg::SSSRQ_OFF_ACK_G0:
          st_next.prdata = {8'h00, hit_g0 ? st_reg.held.interrupt_number : sssrq_pkg::SSSRQ_NUM_NONE};
        sssrq_pkg::SSSRQ_OFF_ACK_G1:
          st_next.prdata = {8'h00, hit_g1 ? st_reg.held.interrupt_number : sssrq_pkg::SSSRQ_NUM_NONE};
        sssrq_pkg::SSSRQ_OFF_STATUS:
        begin
          st_next.prdata[sssrq_pkg::SSSRQ_ST_HELD]   = st_reg.held_valid;
          st_next.prdata[sssrq_pkg::SSSRQ_ST_QUIES]  = st_reg.quiesce_pend;
          st_next.prdata[sssrq_pkg::SSSRQ_ST_UCPEND] = st_reg.uc_pend;
          st_next.prdata[sssrq_pkg::SSSRQ_ST_QCNT +: 2] = q_count;
          st_next.prdata[sssrq_pkg::SSSRQ_ST_BUSY]   = up_valid;
          st_next.prdata[sssrq_pkg::SSSRQ_ST_PRIO +: 8] = st_reg.held.priority_field;
        end
        default: st_next.pslverr = 1'b1;
      endcase
    end

    // bus access edge: writes land, acknowledge reads consume the held interrupt
    if (access_ph)
    begin
      if (pwrite && paddr == sssrq_pkg::SSSRQ_OFF_ENABLE && pstrb[0])
      begin
        // every enable write with pstrb[0] set queues an update
        st_next.en      = pwdata[2:0];
        st_next.uc_pend = 1'b1;
      end
      if (!pwrite && ((paddr == sssrq_pkg::SSSRQ_OFF_ACK_G0 && hit_g0) ||
                      (paddr == sssrq_pkg::SSSRQ_OFF_ACK_G1 && hit_g1)))
        st_next.held_valid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_qack_when_quiet: assert property (
    st_reg.seq == sssrq_pkg::SSSRQ_SEQ_QACK |-> q_empty && !st_reg.held_valid && !$past(st_reg.held_valid))
    else $error("quiesce acknowledge while not quiet");

  a_disabled_set_rel: assert property (
    set_fire && !new_on |-> q_push && q_push_data.interrupt_number == set_cmd.interrupt_number)
    else $error("disabled set not released");

  a_rel_hdr_fields: assert property (
    st_reg.seq == sssrq_pkg::SSSRQ_SEQ_REL_HDR |-> up_beat.data[3:0] == 4'h3 && !up_beat.data[5]
      && up_beat.data[15:8] == 8'h00 && up_beat.data[7:6] == st_reg.rel.number_width_code)
    else $error("bad release header");

  a_rel_upper_zero: assert property (
    st_reg.seq == sssrq_pkg::SSSRQ_SEQ_REL_HI |-> up_beat.data[15:8] == 8'h00 && up_beat.last)
    else $error("release upper halfword not zero on top byte");

  a_rel_kind_flag: assert property (
    q_pop |=> st_reg.seq == sssrq_pkg::SSSRQ_SEQ_REL_HDR && up_beat.data[4] == $past(q_head.virt))
    else $error("release kind flag wrong");

  a_ack_read_number: assert property (
    setup_ph && paddr == sssrq_pkg::SSSRQ_OFF_ACK_G0 && hit_g0
      |=> prdata == {8'h00, $past(st_reg.held.interrupt_number)} ##1 !st_reg.held_valid)
    else $error("acknowledge read returned wrong number or did not consume");

  a_uc_before_rel: assert property (
    st_reg.seq == sssrq_pkg::SSSRQ_SEQ_IDLE && st_reg.uc_pend |=> st_reg.seq == sssrq_pkg::SSSRQ_SEQ_UC_HDR)
    else $error("release overtook enable update");

  a_displace_release: assert property (
    set_fire && new_on && st_reg.held_valid
      |-> q_push && q_push_data.interrupt_number == st_reg.held.interrupt_number
      ##1 st_reg.held.interrupt_number == $past(set_cmd.interrupt_number))
    else $error("displaced interrupt not released");

  a_uc_pad_zero: assert property (
    st_reg.seq == sssrq_pkg::SSSRQ_SEQ_UC_DATA |-> up_beat.data[15:3] == 13'h0000 && up_beat.last)
    else $error("upstream control surplus bytes not zero");

  a_uc_ident_len: assert property (
    st_reg.seq == sssrq_pkg::SSSRQ_SEQ_UC_HDR && up_ready
      |-> up_beat.data == 16'h0018 ##1 st_reg.seq == sssrq_pkg::SSSRQ_SEQ_UC_DATA)
    else $error("upstream control header wrong");

  c_release_sent:  cover property (st_reg.seq == sssrq_pkg::SSSRQ_SEQ_REL_HI && up_ready);
  c_qack_sent:     cover property (st_reg.seq == sssrq_pkg::SSSRQ_SEQ_QACK && up_ready);
  c_uc_then_rel:   cover property (st_reg.seq == sssrq_pkg::SSSRQ_SEQ_UC_DATA ##[1:8]
                                   st_reg.seq == sssrq_pkg::SSSRQ_SEQ_REL_HDR);
  c_displacement:  cover property (set_fire && new_on && st_reg.held_valid);

endmodule

// >>> design/sssrq_pkg.sv
package sssrq_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  SSSRQ_OFF_ENABLE = 8'h00;
  localparam logic [7:0]  SSSRQ_OFF_ACK_G0 = 8'h04;
  localparam logic [7:0]  SSSRQ_OFF_ACK_G1 = 8'h08;
  localparam logic [7:0]  SSSRQ_OFF_STATUS = 8'h0c;
  localparam logic [2:0]  SSSRQ_EN_RESET   = 3'h0;
  localparam int unsigned SSSRQ_EN_G0      = 0;
  localparam int unsigned SSSRQ_EN_G1NS    = 1;
  localparam int unsigned SSSRQ_EN_G1S     = 2;
  // status fields
  localparam int unsigned SSSRQ_ST_HELD    = 0;
  localparam int unsigned SSSRQ_ST_QUIES   = 1;
  localparam int unsigned SSSRQ_ST_UCPEND  = 2;
  localparam int unsigned SSSRQ_ST_QCNT    = 3;
  localparam int unsigned SSSRQ_ST_BUSY    = 5;
  localparam int unsigned SSSRQ_ST_PRIO    = 8;

  // ----------------------------------------------------------------
  // packet codes and fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  SSSRQ_CMD_RELEASE = 4'h3;
  localparam logic [3:0]  SSSRQ_CMD_QACK    = 4'h4;
  localparam logic [3:0]  SSSRQ_CMD_UPCTRL  = 4'h8;
  localparam logic [7:0]  SSSRQ_UC_ID_PHYS  = 8'h00;
  localparam logic [3:0]  SSSRQ_UC_LEN_PHYS = 4'h1;
  localparam logic [1:0]  SSSRQ_WCODE_16    = 2'h0;
  localparam logic [23:0] SSSRQ_NUM_NONE    = 24'h0003ff;
  localparam int unsigned SSSRQ_QDEPTH      = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSSRQ_SEQ_IDLE,
    SSSRQ_SEQ_UC_HDR,
    SSSRQ_SEQ_UC_DATA,
    SSSRQ_SEQ_REL_HDR,
    SSSRQ_SEQ_REL_LO,
    SSSRQ_SEQ_REL_HI,
    SSSRQ_SEQ_QACK
  } sssrq_seq_t;

  typedef struct packed {
    logic [7:0]  priority_field;
    logic        grp;
    logic        mod;
    logic        virt;
    logic [1:0]  number_width_code;
    logic [23:0] interrupt_number;
  } sssrq_set_cmd_t;

  typedef struct packed {
    logic        virt;
    logic [1:0]  number_width_code;
    logic [23:0] interrupt_number;
  } sssrq_rel_entry_t;

  typedef struct packed {
    logic [15:0] data;
    logic        last;
  } sssrq_beat_t;

  typedef struct packed {
    sssrq_seq_t       seq;
    sssrq_beat_t      beat;
    sssrq_rel_entry_t rel;
    logic [2:0]       en;
    logic             uc_pend;
    logic             quiesce_pend;
    logic             held_valid;
    sssrq_set_cmd_t   held;
    logic [31:0]      prdata;
    logic             pslverr;
  } sssrq_state_t;

  typedef struct packed {
    sssrq_rel_entry_t [SSSRQ_QDEPTH-1:0] slots;
    logic                                rd_ptr;
    logic                                wr_ptr;
    logic [1:0]                          count;
  } sssrq_q_state_t;

endpackage

// >>> design/sssrq_rel_queue.sv
`timescale 1ns/1ps
module sssrq_rel_queue (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       push,
  input  wire sssrq_pkg::sssrq_rel_entry_t push_data,
  input  wire logic                       pop,
  output      sssrq_pkg::sssrq_rel_entry_t head,
  output      logic                       full,
  output      logic                       empty,
  output      logic [1:0]                 count
);

  sssrq_pkg::sssrq_q_state_t q_reg;
  sssrq_pkg::sssrq_q_state_t q_next;
  logic                      do_push;
  logic                      do_pop;

  // ----------------------------------------------------------------
  // release holding slots
  // ----------------------------------------------------------------
  assign full    = (q_reg.count == 2'(sssrq_pkg::SSSRQ_QDEPTH));
  assign empty   = (q_reg.count == 2'h0);
  assign count   = q_reg.count;
  assign head    = q_reg.slots[q_reg.rd_ptr];
  // overflow is dropped; the caller stalls sets before that can happen
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;

  // next state
  always_comb
  begin
    q_next = q_reg;
    if (do_push)
    begin
      q_next.slots[q_reg.wr_ptr] = push_data;
      q_next.wr_ptr              = ~q_reg.wr_ptr;
    end
    if (do_pop)
    begin
      q_next.rd_ptr = ~q_reg.rd_ptr;
    end
    q_next.count = q_reg.count + 2'(do_push) - 2'(do_pop);
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

endmodule

// >>> tb/sssrq_redist_model.sv
`timescale 1ns/1ps
module sssrq_redist_model (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  output      logic                      set_valid,
  output      sssrq_pkg::sssrq_set_cmd_t set_cmd,
  input  wire logic                      set_ready,
  output      logic                      quiesce_req,
  input  wire logic                      up_valid,
  input  wire sssrq_pkg::sssrq_beat_t    up_beat,
  output      logic                      up_ready
);
  integer      seed        = 32'h68f8;
  int          outstanding = 0;
  logic        pkt_start   = 1'b1;
  logic [16:0] got[$];

  initial
  begin
    set_valid   = 1'b0;
    set_cmd     = '0;
    quiesce_req = 1'b0;
    up_ready    = 1'b0;
  end

  // ----------------------------------------------------------------
  // upstream sink
  // ----------------------------------------------------------------
  // random stall; surplus upper data bytes are stored but never acted on
  // stall and count returns
  always @(posedge clk)
  begin
    up_ready <= ($random(seed) % 4) != 0;
    if (up_valid && up_ready)
    begin
      got.push_back(up_beat);
      if (pkt_start && up_beat.data[3:0] == sssrq_pkg::SSSRQ_CMD_RELEASE)
        outstanding--;
      pkt_start <= up_beat.last;
    end
  end

  // ----------------------------------------------------------------
  // downstream commands
  // ----------------------------------------------------------------
  // number filter
  function automatic bit legal_num(input int n, input bit aff);
    if (n >= 1020 && n <= 1023)
      return 1'b0;
    if (n > 1023 && n < 8192)
      return !aff && n[9:4] == 6'h0;
    return aff || n < 8192;
  endfunction

  // caller offers only pending, not yet returned numbers it can activate
  // one set at a time
  task automatic send_set(input sssrq_pkg::sssrq_set_cmd_t c);
    if (!legal_num(int'(c.interrupt_number), 1'b1))
      return;
    @(posedge clk);
    // never a third unanswered set; a hang here is left to the watchdog
    while (outstanding >= 2)
      @(posedge clk);
    set_valid <= 1'b1;
    set_cmd   <= c;
    outstanding++;
    do @(posedge clk); while (!set_ready);
    set_valid <= 1'b0;
    set_cmd   <= ~c; // released bus does not keep the old value
  endtask

  task automatic quiesce();
    @(posedge clk);
    quiesce_req <= 1'b1;
    @(posedge clk);
    quiesce_req <= 1'b0;
  endtask
endmodule

// >>> tb/tb_stream_set_release_quiesce.sv
`timescale 1ns/1ps
module tb_stream_set_release_quiesce;
  logic                      clk;
  logic                      sys_rst;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic                      pready;
  logic                      pslverr;
  logic                      set_valid;
  logic                      set_ready;
  logic                      quiesce_req;
  logic                      up_valid;
  logic                      up_ready;
  logic                      err;
  logic [7:0]                paddr;
  logic [3:0]                pstrb;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic [31:0]               rd;
  logic [16:0]               exp_q[$];
  sssrq_pkg::sssrq_set_cmd_t set_cmd;
  sssrq_pkg::sssrq_set_cmd_t ca;
  sssrq_pkg::sssrq_set_cmd_t cb;
  sssrq_pkg::sssrq_set_cmd_t cc;
  sssrq_pkg::sssrq_beat_t    up_beat;
  integer                    seed         = 32'h68f8;
  int                        n_fail       = 0;
  int                        total_checks = 0;

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  sssrq_cpu_stream i_sssrq_cpu_stream (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .set_valid(set_valid), .set_cmd(set_cmd), .set_ready(set_ready),
    .quiesce_req(quiesce_req), .up_valid(up_valid), .up_beat(up_beat), .up_ready(up_ready));

  sssrq_redist_model i_model (.clk(clk), .sys_rst(sys_rst), .set_valid(set_valid), .set_cmd(set_cmd),
    .set_ready(set_ready), .quiesce_req(quiesce_req), .up_valid(up_valid), .up_beat(up_beat),
    .up_ready(up_ready));

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_beat(input logic [16:0] e, input logic [16:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD up_beat expected %h seen %h", e, g);
    end
  endtask

  // idle edge first so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // waits as long as the slave stalls; only the watchdog ends a hang
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // reference model of the upstream stream
  // ----------------------------------------------------------------
  task automatic exp_uc(input logic [2:0] en);
    exp_q.push_back({sssrq_pkg::SSSRQ_UC_ID_PHYS, sssrq_pkg::SSSRQ_UC_LEN_PHYS, sssrq_pkg::SSSRQ_CMD_UPCTRL, 1'b0});
    exp_q.push_back({13'h0, en, 1'b1});
  endtask

  task automatic exp_rel(input sssrq_pkg::sssrq_set_cmd_t c);
    logic wide;
    wide = c.number_width_code != sssrq_pkg::SSSRQ_WCODE_16;
    exp_q.push_back({8'h00, c.number_width_code, 1'b0, c.virt, sssrq_pkg::SSSRQ_CMD_RELEASE, 1'b0});
    exp_q.push_back({c.interrupt_number[15:0], !wide});
    if (wide)
      exp_q.push_back({8'h00, c.interrupt_number[23:16], 1'b1});
  endtask

  // idle tail lets any unexpected extra beat show up in the count
  task automatic check_up();
    int n;
    n = 0;
    while (i_model.got.size() < exp_q.size() && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    repeat (10) @(posedge clk);
    chk_word("beat count", exp_q.size(), i_model.got.size());
    while (exp_q.size() > 0 && i_model.got.size() > 0)
      chk_beat(exp_q.pop_front(), i_model.got.pop_front());
    exp_q.delete();
    i_model.got.delete();
  endtask

  function automatic sssrq_pkg::sssrq_set_cmd_t mk(input logic g, input logic v, input logic [1:0] w);
    sssrq_pkg::sssrq_set_cmd_t c;
    c.priority_field    = 8'($random(seed)) & 8'hf0; // low priority bits unimplemented
    c.grp               = g;
    c.mod               = 1'b0;
    c.virt              = v;
    c.number_width_code = w;
    if (w == 2'h0)
      c.interrupt_number = 24'(32 + $unsigned($random(seed)) % 988);
    else
      c.interrupt_number = 24'(8192 + $unsigned($random(seed)) % 65536);
    return c;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #(100 * 5000);
    n_fail++;
    stop_test();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb   = 4'hf;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, sssrq_pkg::SSSRQ_OFF_STATUS, 32'h0);
    chk_word("status", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk_word("unmapped err", 32'h1, {31'h0, err});
    $display("test reset done");
    apb(1'b1, sssrq_pkg::SSSRQ_OFF_ENABLE, 32'h7);
    exp_uc(3'h7);
    check_up();
    $display("test enable update done");
    ca = mk(1'b0, 1'b0, 2'h0);
    i_model.send_set(ca);
    apb(1'b0, sssrq_pkg::SSSRQ_OFF_ACK_G0, 32'h0);
    i_model.outstanding--;
    chk_word("ack g0", {8'h0, ca.interrupt_number}, rd);
    apb(1'b0, sssrq_pkg::SSSRQ_OFF_ACK_G0, 32'h0);
    chk_word("ack empty", {8'h0, sssrq_pkg::SSSRQ_NUM_NONE}, rd);
    ca     = mk(1'b1, 1'b0, 2'h0);
    ca.mod = 1'b1;
    i_model.send_set(ca);
    apb(1'b0, sssrq_pkg::SSSRQ_OFF_ACK_G0, 32'h0);
    chk_word("ack g0 miss", {8'h0, sssrq_pkg::SSSRQ_NUM_NONE}, rd);
    apb(1'b0, sssrq_pkg::SSSRQ_OFF_ACK_G1, 32'h0);
    i_model.outstanding--;
    chk_word("ack g1", {8'h0, ca.interrupt_number}, rd);
    $display("test acknowledge done");
    cb = mk(1'b1, 1'b1, 2'h1);
    cc = mk(1'b0, 1'b0, 2'h0);
    i_model.send_set(cb);
    i_model.send_set(cc);
    exp_rel(cb);
    check_up();
    $display("test replace done");
    apb(1'b1, sssrq_pkg::SSSRQ_OFF_ENABLE, 32'h0);
    exp_uc(3'h0);
    exp_rel(cc);
    check_up();
    cb = mk(1'b1, 1'b0, 2'h0);
    i_model.send_set(cb);
    exp_rel(cb);
    check_up();
    $display("test disable done");
    apb(1'b1, sssrq_pkg::SSSRQ_OFF_ENABLE, 32'h7);
    exp_uc(3'h7);
    cc = mk(1'b1, 1'b1, 2'h0);
    i_model.send_set(cc);
    i_model.quiesce();
    exp_rel(cc);
    exp_q.push_back({12'h0, sssrq_pkg::SSSRQ_CMD_QACK, 1'b1});
    check_up();
    apb(1'b0, sssrq_pkg::SSSRQ_OFF_STATUS, 32'h0);
    chk_word("status idle", 32'h0, {26'h0, rd[5:0]});
    $display("test quiesce done");
    stop_test();
  end
endmodule
